// *** rtl/srf_pkg.sv ***
package srf_pkg;

  // Register byte offsets on the Wishbone port
  localparam logic [7:0] ADR_CFG  = 8'h00;
  localparam logic [7:0] ADR_MCW  = 8'h04;
  localparam logic [7:0] ADR_WRD1 = 8'h08;
  localparam logic [7:0] ADR_WRD4 = 8'h14;
  localparam logic [7:0] ADR_IST  = 8'h18;
  localparam logic [7:0] ADR_IMSK = 8'h1C;

  // Configuration field positions
  localparam int CFG_PROTO_BIT = 4;
  localparam int CFG_HALL_LSB  = 8;
  localparam int CFG_ON_LSB    = 16;
  localparam int CFG_PROC_LSB  = 20;

  // Data-field length limits and reset values
  localparam logic [3:0]  LEN_MIN     = 4'h8;
  localparam logic [3:0]  LEN_MAX     = 4'hB;
  localparam logic [3:0]  LEN_RST     = 4'hB;
  localparam logic [15:0] MCW_RST     = 16'h0000;
  localparam logic [11:0] IRQ_RST     = 12'h000;
  localparam logic [15:0] WORD_INIT   = 16'hE000;

  // Result field codes
  localparam logic [11:0] CODE_NONE = 12'h000;
  localparam logic [11:0] CODE_ILIM = 12'h010;
  localparam logic [11:0] CODE_PERR = 12'h012;
  localparam logic [11:0] CODE_FEW  = 12'h019;
  localparam logic [11:0] CODE_MANY = 12'h01A;

  // Word bit positions and serial length
  localparam int         DATA_FLAG = 11;
  localparam int         LOST_BIT  = 12;
  localparam int         PAR_BIT   = 13;
  localparam logic [4:0] SER_LAST  = 5'h0F;

  // Channel state field of each word
  typedef enum logic [1:0] {
    CHS_OFF    = 2'b00,
    CHS_NOPROC = 2'b01,
    CHS_PROC   = 2'b10,
    CHS_REPORT = 2'b11
  } srf_stat_t;

  // One decoded message from the Manchester receiver
  typedef struct packed {
    logic [15:0] bits;
    logic [4:0]  nbits;
    logic        bit_err;
  } srf_msg_t;

  // Block configuration
  typedef struct packed {
    logic [3:0] len;
    logic       proto_b;
    logic [1:0] hall;
    logic [3:0] on;
    logic [3:0] proc;
  } srf_cfg_t;

  // Set bit 13 so the whole word holds an odd count of ones
  function automatic logic [15:0] srf_with_par(input logic [15:0] w);
    logic [15:0] r;
    r          = w;
    r[PAR_BIT] = ~^{w[15:14], w[12:0]};
    return r;
  endfunction : srf_with_par

endpackage : srf_pkg

// *** rtl/srf_slot.sv ***
`timescale 1ns/100ps
`default_nettype none
module srf_slot
  import srf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Store and pop
  input  wire logic        wr_i,
  input  wire logic [11:0] word_i,
  input  wire logic        pop_i,
  // Slot state
  output logic             full_o,
  output logic             lost_o,
  output logic             rpt_o,
  output logic [11:0]      dat_o
);

  ////////////////////////////////////////////////////////////////
  // One-entry buffer; a word hitting a full slot is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_o <= 1'b0;
      dat_o  <= CODE_NONE;
    end else if (ce_i) begin
      if (pop_i) begin
        full_o <= wr_i;
        dat_o  <= wr_i ? word_i : CODE_NONE;
      end else if (wr_i && !full_o) begin
        full_o <= 1'b1;
        dat_o  <= word_i;
      end
    end
  end

  // Lost flag; a pop clears it, and a write in the pop cycle is stored, not dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lost_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_i && full_o && !pop_i) begin
        lost_o <= 1'b1;
      end else if (pop_i) begin
        lost_o <= 1'b0;
      end
    end
  end

  // Report form holds until the first new word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rpt_o <= 1'b1;
    end else if (ce_i && wr_i) begin
      rpt_o <= 1'b0;
    end
  end

endmodule : srf_slot
`default_nettype wire

// *** rtl/srf_serializer.sv ***
`timescale 1ns/100ps
`default_nettype none
module srf_serializer
  import srf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Load and shift strobes
  input  wire logic        load_i,
  input  wire logic [15:0] word_i,
  input  wire logic        lsb_first_i,
  input  wire logic        shift_i,
  // Serial data
  output logic             sdo_o
);

  typedef enum logic {SER_IDLE = 1'b0, SER_SHIFT = 1'b1} srf_ser_t;

  srf_ser_t    state_ff;
  logic [15:0] sh_ff;
  logic [4:0]  cnt_ff;
  logic        lsb_ff;

  ////////////////////////////////////////////////////////////////
  // Shifter; a load restarts any word in flight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= SER_IDLE;
      sh_ff    <= 16'h0000;
      cnt_ff   <= 5'h00;
      lsb_ff   <= 1'b0;
      sdo_o    <= 1'b0;
    end else if (ce_i) begin
      if (load_i) begin
        state_ff <= SER_SHIFT;
        sh_ff    <= word_i;
        cnt_ff   <= SER_LAST;
        lsb_ff   <= lsb_first_i;
        sdo_o    <= lsb_first_i ? word_i[0] : word_i[15];
      end else if (shift_i) begin
        unique case (state_ff)
          SER_IDLE: begin
            sdo_o <= 1'b0;
          end
          SER_SHIFT: begin
            sh_ff  <= lsb_ff ? (sh_ff >> 1) : (sh_ff << 1);
            sdo_o  <= (cnt_ff == 5'h00) ? 1'b0 : (lsb_ff ? sh_ff[1] : sh_ff[14]);
            cnt_ff <= cnt_ff - 5'h01;
            if (cnt_ff == 5'h00) begin
              state_ff <= SER_IDLE;
            end
          end
        endcase
      end
    end
  end

endmodule : srf_serializer
`default_nettype wire

// *** rtl/srf_formatter.sv ***
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module srf_formatter
  import srf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Decoder and fault events
  input  wire logic        msg_valid_i,
  input  wire logic [1:0]  msg_chan_i,
  input  wire srf_msg_t    msg_i,
  input  wire logic [3:0]  ilim_i,
  input  wire logic [3:0]  perr_i,
  input  wire logic        glob_valid_i,
  input  wire logic [3:0]  glob_code_i,
  // Serial readout
  input  wire logic        ser_load_i,
  input  wire logic [1:0]  ser_chan_i,
  input  wire logic        ser_shift_i,
  output logic             ser_sdo_o,
  // Interrupt
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////
  // Declarations
  srf_cfg_t    cfg_ff;
  logic [15:0] mcw_ff;
  logic [11:0] ist_ff, imsk_ff, nxt_ist, msg_code;
  logic        glob_done_ff, req, wr_acc, rd_acc, msg_ok, ch_acc;
  logic [31:0] bm, cfg_rd, cfg_new;
  logic [2:0]  ch_rd;
  logic [3:0]  hall, pop, put_wr, is_dat, full, lost, rpt;
  logic [11:0] put_word [4], slot_dat [4];
  logic [15:0] ch_word  [4];

  // Byte-lane mask from the select lines
  function automatic logic [31:0] lanes(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lanes

  // Channel word index hit by an address: {hit, index}
  function automatic logic [2:0] ch_of(input logic [7:0] adr);
    logic [7:0] d;
    d = adr - ADR_WRD1;
    return {(adr >= ADR_WRD1) && (adr <= ADR_WRD4), d[3:2]};
  endfunction : ch_of

  ////////////////////////////////////////////////////////////////
  // Bus decode; one request per ack, answer one cycle later
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_acc = ce_i && req && wb_we_i;
  assign rd_acc = ce_i && req && !wb_we_i;
  assign bm     = lanes(wb_sel_i);
  assign ch_rd  = ch_of(wb_adr_i);

  // Configuration read-back image
  always_comb begin
    cfg_rd                                    = 32'h0000_0000;
    cfg_rd[3:0]                               = cfg_ff.len;
    cfg_rd[CFG_PROTO_BIT]                     = cfg_ff.proto_b;
    cfg_rd[CFG_HALL_LSB+1:CFG_HALL_LSB]       = cfg_ff.hall;
    cfg_rd[CFG_ON_LSB+3:CFG_ON_LSB]           = cfg_ff.on;
    cfg_rd[CFG_PROC_LSB+3:CFG_PROC_LSB]       = cfg_ff.proc;
    cfg_new                                   = (cfg_rd & ~bm) | (wb_dat_i & bm);
  end

  // Ack strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req;
    end
  end

  // Read data; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_acc) begin
      if (ch_rd[2]) begin
        wb_dat_o <= {16'h0000, ch_word[ch_rd[1:0]]};
      end else begin
        unique case (wb_adr_i)
          ADR_CFG:  wb_dat_o <= cfg_rd;
          ADR_MCW:  wb_dat_o <= {16'h0000, mcw_ff};
          ADR_IST:  wb_dat_o <= {20'h00000, ist_ff};
          ADR_IMSK: wb_dat_o <= {20'h00000, imsk_ff};
          default:  wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Configuration; a length outside 8..11 is refused, old one kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= '{len: LEN_RST, proto_b: 1'b0, hall: 2'b00, on: 4'h0, proc: 4'h0};
    end else if (wr_acc && wb_adr_i == ADR_CFG) begin
      if (cfg_new[3:0] >= LEN_MIN && cfg_new[3:0] <= LEN_MAX) begin
        cfg_ff.len <= cfg_new[3:0];
      end
      cfg_ff.proto_b <= cfg_new[CFG_PROTO_BIT];
      cfg_ff.hall    <= cfg_new[CFG_HALL_LSB+1:CFG_HALL_LSB];
      cfg_ff.on      <= cfg_new[CFG_ON_LSB+3:CFG_ON_LSB];
      cfg_ff.proc    <= cfg_new[CFG_PROC_LSB+3:CFG_PROC_LSB];
    end
  end

  // Main configuration word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mcw_ff <= MCW_RST;
    end else if (wr_acc && wb_adr_i == ADR_MCW) begin
      mcw_ff <= (mcw_ff & ~bm[15:0]) | (wb_dat_i[15:0] & bm[15:0]);
    end
  end

  // Hall select exists for channels three and four only
  assign hall = {cfg_ff.hall, 2'b00};

  ////////////////////////////////////////////////////////////////
  // Message check against the configured data-field length
  always_comb begin
    msg_ok   = 1'b0;
    msg_code = CODE_NONE;
    if (msg_i.bit_err || msg_i.nbits < {1'b0, cfg_ff.len}) begin
      msg_code = CODE_FEW;
    end else if (msg_i.nbits > {1'b0, cfg_ff.len}) begin
      msg_code = CODE_MANY;
    end else begin
      msg_ok   = 1'b1;
      msg_code = msg_i.bits[11:0] & ~(12'hFFF << cfg_ff.len);
      msg_code[DATA_FLAG] = cfg_ff.proto_b;
    end
  end

  // Per-channel event choice: current limit, parity, message, global
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      put_wr[i]   = 1'b0;
      is_dat[i]   = 1'b0;
      put_word[i] = CODE_NONE;
      if (ilim_i[i]) begin
        put_wr[i]   = 1'b1;
        put_word[i] = CODE_ILIM;
      end else if (perr_i[i]) begin
        put_wr[i]   = 1'b1;
        put_word[i] = CODE_PERR;
      end else if (msg_valid_i && msg_chan_i == 2'(i) && !hall[i]
                   && cfg_ff.on[i] && cfg_ff.proc[i]) begin
        put_wr[i]   = 1'b1;
        is_dat[i]   = msg_ok;
        put_word[i] = msg_code;
      end else if (i == 0 && glob_valid_i && !glob_done_ff) begin
        put_wr[i]   = 1'b1;
        put_word[i] = {8'h00, glob_code_i};
      end
    end
  end

  // Global code latched once until channel one is read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      glob_done_ff <= 1'b0;
    end else if (ce_i) begin
      if (glob_valid_i && !ilim_i[0] && !perr_i[0]) begin
        glob_done_ff <= 1'b1;
      end else if (pop[0]) begin
        glob_done_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Channel slots and read-back words
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pop[i] = (rd_acc && ch_rd[2] && ch_rd[1:0] == 2'(i))
               || (ce_i && ser_load_i && ser_chan_i == 2'(i));
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_slot
    srf_slot u_slot (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .wr_i   (put_wr[g]),
      .word_i (put_word[g]),
      .pop_i  (pop[g]),
      .full_o (full[g]),
      .lost_o (lost[g]),
      .rpt_o  (rpt[g]),
      .dat_o  (slot_dat[g])
    );
  end

  // Word = state, parity, lost flag, result field
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      srf_stat_t   cst;
      logic [11:0] pay;
      cst = CHS_OFF;
      pay = slot_dat[i];
      if (rpt[i]) begin
        cst = CHS_REPORT;
        pay = (i == 0) ? mcw_ff[11:0] : CODE_NONE;
      end else if (cfg_ff.on[i]) begin
        cst = cfg_ff.proc[i] ? CHS_PROC : CHS_NOPROC;
      end
      ch_word[i] = srf_with_par({cst, 1'b0, lost[i] && !rpt[i], pay});
    end
  end

  ////////////////////////////////////////////////////////////////
  // Serial readout; bit order follows the protocol
  srf_serializer u_ser (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .load_i      (ser_load_i),
    .word_i      (ch_word[ser_chan_i]),
    .lsb_first_i (cfg_ff.proto_b),
    .shift_i     (ser_shift_i),
    .sdo_o       (ser_sdo_o)
  );

  ////////////////////////////////////////////////////////////////
  // Interrupt status: [3:0] lost, [7:4] fault, [11:8] data; set wins
  always_comb begin
    nxt_ist = ist_ff;
    if (wr_acc && wb_adr_i == ADR_IST) begin
      nxt_ist = ist_ff & ~(wb_dat_i[11:0] & bm[11:0]);
    end
    nxt_ist = nxt_ist | {put_wr & is_dat, put_wr & ~is_dat, put_wr & full & ~pop};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_ff <= IRQ_RST;
    end else if (ce_i) begin
      ist_ff <= nxt_ist;
    end
  end

  // Mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imsk_ff <= IRQ_RST;
    end else if (wr_acc && wb_adr_i == ADR_IMSK) begin
      imsk_ff <= (imsk_ff & ~bm[11:0]) | (wb_dat_i[11:0] & bm[11:0]);
    end
  end

  // Level interrupt, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(nxt_ist & imsk_ff);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Message really stored; a global code landing on channel one must not count
  assign ch_acc = ce_i && msg_valid_i && put_wr[msg_chan_i] && !ilim_i[msg_chan_i]
                  && !perr_i[msg_chan_i] && !full[msg_chan_i] && !pop[msg_chan_i]
                  && !hall[msg_chan_i] && cfg_ff.on[msg_chan_i] && cfg_ff.proc[msg_chan_i];
  property p_len_keep;
    wr_acc && wb_adr_i == ADR_CFG && wb_sel_i[0] && wb_dat_i[3:0] < LEN_MIN |=> $stable(cfg_ff.len);
  endproperty
  a_len_keep: assert property (p_len_keep) else $error("bad length accepted");
  property p_rjust;
    ch_acc && msg_ok |=> (slot_dat[$past(msg_chan_i)][10:0] >> $past(cfg_ff.len)) == 11'h000;
  endproperty
  a_rjust: assert property (p_rjust) else $error("data not right justified");
  property p_many;
    ch_acc && !msg_i.bit_err && msg_i.nbits > {1'b0, cfg_ff.len} |=> slot_dat[$past(msg_chan_i)] == CODE_MANY;
  endproperty
  a_many: assert property (p_many) else $error("too many bits not coded");
  property p_few;
    ch_acc && msg_i.nbits < {1'b0, cfg_ff.len} |=> slot_dat[$past(msg_chan_i)] == CODE_FEW;
  endproperty
  a_few: assert property (p_few) else $error("too few bits not coded");
  property p_flag;
    ch_acc && cfg_ff.proto_b |=> slot_dat[$past(msg_chan_i)][DATA_FLAG] == $past(msg_ok);
  endproperty
  a_flag: assert property (p_flag) else $error("data flag wrong");
  property p_hall_ilim;
    ce_i && hall[3] && ilim_i[3] && !full[3] && !pop[3] |=> slot_dat[3] == CODE_ILIM && ch_word[3][11:0] == CODE_ILIM;
  endproperty
  a_hall_ilim: assert property (p_hall_ilim) else $error("hall limit code wrong");
  property p_hall_ign;
    ce_i && msg_valid_i && msg_chan_i == 2'h2 && hall[2] && !ilim_i[2] && !perr_i[2] && !pop[2] |=> $stable(full[2]);
  endproperty
  a_hall_ign: assert property (p_hall_ign) else $error("hall channel took a message");
  property p_init;
    $fell(rst_i) |-> ch_word[1] == WORD_INIT && ch_word[3] == WORD_INIT && ch_word[0][15:14] == CHS_REPORT;
  endproperty
  a_init: assert property (p_init) else $error("reset words wrong");
  property p_lost;
    ce_i && put_wr[1] && full[1] && !pop[1] |=> lost[1] && ch_word[1][LOST_BIT] && ^ch_word[1];
  endproperty
  a_lost: assert property (p_lost) else $error("lost flag or parity wrong");

endmodule : srf_formatter
`default_nettype wire

// *** test/srf_sat_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module srf_sat_model
  import srf_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Decoder side
  output logic            msg_valid_o,
  output logic [1:0]      msg_chan_o,
  output var srf_msg_t    msg_o,
  // Loop fault events
  output logic [3:0]      ilim_o,
  output logic [3:0]      perr_o
);
  // Idle values at time zero
  initial begin
    msg_valid_o = 1'b0;
    msg_chan_o  = 2'h0;
    msg_o       = '0;
    ilim_o      = 4'h0;
    perr_o      = 4'h0;
  end

  ////////////////////////////////////////////////////////////////
  // One decoded message; payload inverted once valid drops so stale data never looks good
  task send(input logic [1:0] c, input logic [15:0] b, input logic [4:0] n, input logic e);
    srf_msg_t m;
    m = '{bits: b, nbits: n, bit_err: e};
    @(posedge clk_i);
    msg_valid_o <= 1'b1;
    msg_chan_o  <= c;
    msg_o       <= m;
    @(posedge clk_i);
    msg_valid_o <= 1'b0;
    msg_o       <= ~m;
  endtask : send

  // One-cycle current-limit and parity event pulses
  task fault(input logic [3:0] il, input logic [3:0] pe);
    @(posedge clk_i);
    ilim_o <= il;
    perr_o <= pe;
    @(posedge clk_i);
    ilim_o <= 4'h0;
    perr_o <= 4'h0;
  endtask : fault
endmodule : srf_sat_model
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  import srf_pkg::*;

  typedef struct packed {
    logic [3:0]  len;
    logic [4:0]  nb;
    logic [15:0] bits;
    logic        err;
    logic [11:0] res;
  } srf_row_t;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, ser_sdo_o, irq_o, mv;
  logic [1:0]  mc;
  srf_msg_t    m;
  logic [3:0]  il, pe;
  logic        glob_v = 1'b0;
  logic [3:0]  glob_c = 4'h0;
  logic        ld = 1'b0, sh = 1'b0;
  logic [1:0]  sch = 2'h0;
  logic [15:0] got;
  int          bad_count = 0;
  int          n_compared = 0;
  srf_row_t    rows [8] = '{
    '{4'h8, 5'h08, 16'h005A, 1'b0, 12'h85A}, '{4'h8, 5'h09, 16'h01FF, 1'b0, 12'h01A},
    '{4'h8, 5'h07, 16'h007F, 1'b0, 12'h019}, '{4'h9, 5'h09, 16'hFFFF, 1'b0, 12'h9FF},
    '{4'hB, 5'h0B, 16'h07FF, 1'b0, 12'hFFF}, '{4'hA, 5'h0A, 16'h0155, 1'b1, 12'h019},
    '{4'hA, 5'h0A, 16'h0155, 1'b0, 12'h955}, '{4'h7, 5'h0A, 16'h02AA, 1'b0, 12'hAAA}};

  // Clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  srf_formatter dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .msg_valid_i(mv), .msg_chan_i(mc), .msg_i(m), .ilim_i(il), .perr_i(pe),
    .glob_valid_i(glob_v), .glob_code_i(glob_c), .ser_load_i(ld), .ser_chan_i(sch),
    .ser_shift_i(sh), .ser_sdo_o(ser_sdo_o), .irq_o(irq_o));

  srf_sat_model sat (.clk_i(clk_i), .msg_valid_o(mv), .msg_chan_o(mc), .msg_o(m),
    .ilim_o(il), .perr_o(pe));

  ////////////////////////////////////////////////////////////////
  // Odd parity into bit 13, worked out here on purpose
  function automatic logic [15:0] wpar(input logic [15:0] w);
    wpar     = w;
    wpar[13] = ~^{w[15:14], w[12:0]};
  endfunction : wpar

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Classic cycle: hold until ack, take data at that edge, then release
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0);
  endtask : wb

  task results;
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    results();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Table of ordinary messages on channel two; length 7 must be refused
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, ADR_CFG, 32'h00FF0010 | 32'(rows[i].len));
      sat.send(2'h1, rows[i].bits, rows[i].nb, rows[i].err);
      wb(1'b0, 8'h0C, 32'h0);
      chk(q[15:0], wpar({4'h8, rows[i].res}));
    end
    // Reset words; a second reset mid-run
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wb(1'b0, ADR_WRD1 + 8'(4 * c), 32'h0);
      chk(q[15:0], 16'hE000);
    end
    // Report form of channel one follows the main configuration word
    wb(1'b1, ADR_MCW, 32'h0000_0123);
    wb(1'b0, ADR_WRD1, 32'h0);
    chk(q[15:0], wpar(16'hC123));
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    // Serial word: MSB first and D11 clear in the first protocol, LSB first in the second
    for (int p = 0; p < 2; p++) begin
      wb(1'b1, ADR_CFG, 32'h00FF0008 | 32'(p << 4));
      sat.send(2'h1, 16'h005A, 5'h08, 1'b0);
      @(posedge clk_i);
      ld  <= 1'b1;
      sch <= 2'h1;
      @(posedge clk_i);
      ld <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        @(posedge clk_i);
        got[(p == 1) ? i : 15 - i] = ser_sdo_o;
        sh <= 1'b1;
        @(posedge clk_i);
        sh <= 1'b0;
      end
      chk(got, wpar((p == 1) ? 16'h885A : 16'h805A));
    end
    // Overflow, mask and write-one-to-clear
    wb(1'b1, ADR_IMSK, 32'h2);
    sat.send(2'h1, 16'h005A, 5'h08, 1'b0);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b0);
    sat.send(2'h1, 16'h00A5, 5'h08, 1'b0);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wb(1'b0, 8'h0C, 32'h0);
    chk(q[15:0], wpar(16'h985A));
    wb(1'b1, ADR_IST, 32'hFFF);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b0);
    // Hall channels three and four: fault codes, no messages, no global codes
    wb(1'b1, ADR_CFG, 32'h00FF031B);
    sat.fault(4'hC, 4'h0);
    wb(1'b0, 8'h10, 32'h0);
    chk(q[11:0], CODE_ILIM);
    wb(1'b0, ADR_WRD4, 32'h0);
    chk(q[11:0], CODE_ILIM);
    sat.fault(4'h0, 4'h4);
    wb(1'b0, 8'h10, 32'h0);
    chk(q[11:0], CODE_PERR);
    sat.send(2'h2, 16'h005A, 5'h0B, 1'b0);
    @(posedge clk_i);
    glob_v <= 1'b1;
    glob_c <= 4'h2;
    @(posedge clk_i);
    glob_v <= 1'b0;
    wb(1'b0, 8'h10, 32'h0);
    chk(q[11:0], CODE_NONE);
    wb(1'b0, ADR_WRD1, 32'h0);
    chk(q[11:0], 12'h002);
    results();
  end
endmodule : tb
`default_nettype wire
